//--- design/asram_defines.vh
`ifndef ASRAM_DEFINES_VH
`define ASRAM_DEFINES_VH
// ==========================================
// Geometry
`define ASRAM_ADDR_W        18
`define ASRAM_DATA_W        16
`define ASRAM_LANE_W        8
// ==========================================
// Timing figures in ns
`define ASRAM_CLK_PERIOD_NS 25
`define ASRAM_ACCESS_NS     10
`define ASRAM_WE_PULSE_NS   7
`define ASRAM_SETUP_NS      5
`define ASRAM_FLOAT_NS      5
`define ASRAM_HOLD_NS       0
// Least times round up, at least one cycle
`define ASRAM_CEIL(ns) (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_MIN1(c)  (((c) < 1) ? 1 : (c))
`define ASRAM_RD_CYC   `ASRAM_MIN1(`ASRAM_CEIL(`ASRAM_ACCESS_NS) + 1)
`define ASRAM_WR_CYC   `ASRAM_MIN1(`ASRAM_CEIL(`ASRAM_FLOAT_NS + `ASRAM_SETUP_NS))
`define ASRAM_WP_CYC   `ASRAM_MIN1(`ASRAM_CEIL(`ASRAM_WE_PULSE_NS))
`define ASRAM_CNT_W    4
`endif

//--- design/asram_lane_io.v
`timescale 1ns/1ps
// ==========================================
// Per-lane data pin driver
module asram_lane_io #(
    parameter LANE_W = 8
) (
    input  wire              ref_clk,
    input  wire              resetn,
    input  wire              clk_en,
    input  wire              drive,
    input  wire [LANE_W-1:0] wdata,
    output reg  [LANE_W-1:0] dq_out,
    output reg               dq_oe
);
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dq_out <= {LANE_W{1'b0}};
            dq_oe  <= 1'b0;
        end else if (clk_en) begin
            dq_out <= wdata;
            dq_oe  <= drive;
        end
    end
endmodule // asram_lane_io

//--- design/asram_host.v
// Operation
// - Write starts both low, rise ends
// - Data held across write-ending edge
// - Write cycle covers float plus setup
// - Address valid before select falls
// - Never drive pins device is driving
// - Write enable high throughout reads
// - Deselected before and during retention
`timescale 1ns/1ps
`include "asram_defines.vh"
module asram_host #(
    parameter ADDR_W = `ASRAM_ADDR_W,
    parameter DATA_W = `ASRAM_DATA_W,
    parameter LANE_W = `ASRAM_LANE_W
) (
    input  wire              ref_clk,
    input  wire              resetn,
    input  wire              clk_en,
    input  wire              req_valid,
    input  wire              req_write,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [DATA_W-1:0] req_wdata,
    input  wire [1:0]        req_lane_en,
    input  wire              retention_req,
    output reg               req_ready,
    output reg               rsp_valid,
    output reg  [DATA_W-1:0] rsp_rdata,
    output reg               in_retention,
    output reg  [ADDR_W-1:0] mem_addr,
    output reg               chip_select_n,
    output reg               output_enable_n,
    output reg               write_enable_n,
    output reg               low_byte_enable_n,
    output reg               high_byte_enable_n,
    input  wire [DATA_W-1:0] dq_in,
    output wire [DATA_W-1:0] dq_out,
    output wire [DATA_W-1:0] dq_oe
);
    localparam NLANE = DATA_W / LANE_W;
    localparam CNT_W = `ASRAM_CNT_W;

    // ==========================================
    // Sequencer states
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_RSET  = 3'h1;
    localparam [2:0] S_READ  = 3'h2;
    localparam [2:0] S_WSET  = 3'h3;
    localparam [2:0] S_WPUL  = 3'h4;
    localparam [2:0] S_WEND  = 3'h5;
    localparam [2:0] S_RETN  = 3'h6;

    // ==========================================
    // Wait counts
    // Integers first so the cut to counter width is deliberate
    localparam integer     RD_CYC_I = `ASRAM_RD_CYC;
    localparam integer     WP_CYC_I = `ASRAM_WP_CYC;
    localparam integer     WR_CYC_I = `ASRAM_WR_CYC;
    localparam integer     RD_END_I = RD_CYC_I - 1;
    localparam [CNT_W-1:0] RD_END   = RD_END_I[CNT_W-1:0];
    localparam [CNT_W-1:0] WP_CYC   = WP_CYC_I[CNT_W-1:0];
    localparam [CNT_W-1:0] WR_CYC   = WR_CYC_I[CNT_W-1:0];

    // ==========================================
    // Storage
    reg [2:0]             state;
    reg [`ASRAM_CNT_W-1:0] cnt;
    reg [DATA_W-1:0]      wdata;
    reg [1:0]             lanes;
    reg                   drive;
    wire [NLANE-1:0]      lane_oe;

    // ==========================================
    // Decode helpers
    // Lane pin level: a set enable bit pulls the pin low
    function lane_pin_n;
        input [1:0] en;
        input       idx;
        begin
            lane_pin_n = ~en[idx];
        end
    endfunction

    // Shared by the read wait and the write pulse
    function cnt_reached;
        input [CNT_W-1:0] c;
        input [CNT_W-1:0] lim;
        begin
            cnt_reached = (c >= lim);
        end
    endfunction

    // ==========================================
    // Data pin drivers
    genvar g;
    generate
        for (g = 0; g < NLANE; g = g + 1) begin : g_lane
            wire [LANE_W-1:0] lo;
            wire              loe;
            asram_lane_io #(.LANE_W(LANE_W)) u_lane (
                .ref_clk (ref_clk),
                .resetn  (resetn),
                .clk_en  (clk_en),
                .drive   (drive & lanes[g]),
                .wdata   (wdata[g*LANE_W +: LANE_W]),
                .dq_out  (lo),
                .dq_oe   (loe)
            );
            assign dq_out[g*LANE_W +: LANE_W] = lo;
            assign dq_oe[g*LANE_W +: LANE_W]  = {LANE_W{loe}};
            assign lane_oe[g]                 = loe;
        end
    endgenerate

    // ==========================================
    // Sequencer
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state              <= S_IDLE;
            cnt                <= {`ASRAM_CNT_W{1'b0}};
            wdata              <= {DATA_W{1'b0}};
            lanes              <= 2'h0;
            drive              <= 1'b0;
            req_ready          <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= {DATA_W{1'b0}};
            in_retention       <= 1'b0;
            mem_addr           <= {ADDR_W{1'b0}};
            chip_select_n      <= 1'b1;
            output_enable_n    <= 1'b1;
            write_enable_n     <= 1'b1;
            low_byte_enable_n  <= 1'b1;
            high_byte_enable_n <= 1'b1;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            case (state)
            S_IDLE: begin
                req_ready <= 1'b1;
                if (retention_req) begin
                    req_ready     <= 1'b0;
                    chip_select_n <= 1'b1;
                    in_retention  <= 1'b1;
                    state         <= S_RETN;
                end else if (req_valid && req_ready) begin
                    req_ready          <= 1'b0;
                    mem_addr           <= req_addr;
                    wdata              <= req_wdata;
                    lanes              <= req_lane_en;
                    low_byte_enable_n  <= lane_pin_n(req_lane_en, 1'b0);
                    high_byte_enable_n <= lane_pin_n(req_lane_en, 1'b1);
                    write_enable_n     <= 1'b1;
                    output_enable_n    <= 1'b1;
                    cnt                <= {`ASRAM_CNT_W{1'b0}};
                    state              <= req_write ? S_WSET : S_RSET;
                end
            end
            S_RSET: begin
                // Select once host drivers are off
                if (lane_oe == {NLANE{1'b0}}) begin
                    chip_select_n   <= 1'b0;
                    output_enable_n <= 1'b0;
                    state           <= S_READ;
                end
            end
            S_READ: begin
                cnt <= cnt + 1'b1;
                if (cnt_reached(cnt, RD_END)) begin
                    rsp_rdata       <= dq_in;
                    rsp_valid       <= 1'b1;
                    chip_select_n   <= 1'b1;
                    output_enable_n <= 1'b1;
                    state           <= S_IDLE;
                end
            end
            S_WSET: begin
                chip_select_n <= 1'b0;
                drive         <= 1'b1;
                state         <= S_WPUL;
            end
            S_WPUL: begin
                write_enable_n <= 1'b0;
                cnt            <= cnt + 1'b1;
                if (cnt_reached(cnt, WP_CYC) && cnt_reached(cnt, WR_CYC)) begin
                    write_enable_n <= 1'b1;
                    chip_select_n  <= 1'b1;
                    // Lane stage holds data one edge
                    drive          <= 1'b0;
                    state          <= S_WEND;
                end
            end
            S_WEND: begin
                // Lanes close with the last driven cycle
                low_byte_enable_n  <= 1'b1;
                high_byte_enable_n <= 1'b1;
                rsp_valid          <= 1'b1;
                state              <= S_IDLE;
            end
            S_RETN: begin
                chip_select_n <= 1'b1;
                if (!retention_req) begin
                    in_retention <= 1'b0;
                    state        <= S_IDLE;
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule // asram_host

//--- bench/asram_model.sv
`timescale 1ns/1ps
// ==========================================
// Behavioural memory device
module asram_model (
    input  wire [17:0] addr,
    input  wire        cs_n,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire        lb_n,
    input  wire        hb_n,
    input  wire [15:0] dq,
    output wire [15:0] q,
    output wire [15:0] q_oe
);
    reg  [15:0] mem [0:262143];
    reg  [15:0] last;
    wire        rd = !cs_n && !oe_n && we_n;
    wire        wr = !cs_n && !we_n;
    wire [15:0] word = mem[addr];
    assign q_oe = {{8{rd && !hb_n}}, {8{rd && !lb_n}}};
    // Floating lines show inverted last value, never a stale one
    assign q = (q_oe & word) | (~q_oe & ~last);
    always @(word or rd) begin
        if (rd) last = word;
    end
    always @(negedge wr) begin
        if (!lb_n) mem[addr][7:0] = dq[7:0];
        if (!hb_n) mem[addr][15:8] = dq[15:8];
    end
endmodule // asram_model

//--- bench/asram_host_chk.sv
`timescale 1ns/1ps
module asram_host_chk (
    input wire        ref_clk,
    input wire        resetn,
    input wire        req_valid,
    input wire        req_write,
    input wire        retention_req,
    input wire        req_ready,
    input wire        rsp_valid,
    input wire        in_retention,
    input wire [17:0] mem_addr,
    input wire        chip_select_n,
    input wire        output_enable_n,
    input wire        write_enable_n,
    input wire        low_byte_enable_n,
    input wire [15:0] dq_out,
    input wire [15:0] dq_oe
);
    wire rd_take = req_valid && req_ready && !req_write && !retention_req;
    // ==========================================
    // Protocol checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_RD_WE: assert property (!chip_select_n && !output_enable_n |-> write_enable_n)
        else $error("write enable low in read");
    AST_NO_FIGHT: assert property (|dq_oe |-> output_enable_n)
        else $error("host drives while device outputs");
    AST_JOINT: assert property ($rose(write_enable_n) |-> $rose(chip_select_n))
        else $error("write end not joint");
    AST_HOLD: assert property ($rose(write_enable_n) |-> $stable(dq_oe) && $stable(dq_out))
        else $error("data not held at write end");
    AST_WLEN: assert property ($fell(write_enable_n) |->
        ##1 ($rose(write_enable_n) && $stable(dq_oe)))
        else $error("write pulse wrong");
    AST_ADDR: assert property ($fell(chip_select_n) |-> $stable(mem_addr))
        else $error("address moved at select");
    AST_RET: assert property (in_retention |-> chip_select_n)
        else $error("selected in retention");
    AST_LANE: assert property (|dq_oe[7:0] |-> !low_byte_enable_n)
        else $error("low lane driven while disabled");
    AST_RLAT: assert property (rd_take |-> ##4 rsp_valid)
        else $error("read answer late");
    cover property ($rose(write_enable_n));
    cover property (in_retention);
    cover property (rsp_valid);
endmodule // asram_host_chk
bind asram_host asram_host_chk asram_host_chk_i (.ref_clk, .resetn, .req_valid, .req_write,
    .retention_req, .req_ready, .rsp_valid, .in_retention, .mem_addr, .chip_select_n,
    .output_enable_n, .write_enable_n, .low_byte_enable_n, .dq_out, .dq_oe);

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    reg         ref_clk = 0, resetn = 0, req_valid = 0, req_write = 0, retention_req = 0, w;
    reg  [17:0] req_addr = 0, a;
    reg  [15:0] req_wdata = 0, d, r, m;
    reg  [1:0]  req_lane_en = 0, l;
    reg  [36:0] rows [0:10];
    wire        req_ready, rsp_valid, in_retention, chip_select_n, output_enable_n;
    wire        write_enable_n, low_byte_enable_n, high_byte_enable_n;
    wire [17:0] mem_addr;
    wire [15:0] rsp_rdata, dq_out, dq_oe, q, q_oe;
    wire [15:0] dq_in = (dq_oe & dq_out) | (~dq_oe & q);
    integer     n_fail = 0, n_checks = 0, i, t;
    always #12.5 ref_clk = ~ref_clk;
    asram_host asram_host_i (.ref_clk, .resetn, .clk_en(1'b1), .req_valid, .req_write,
        .req_addr, .req_wdata, .req_lane_en, .retention_req, .req_ready, .rsp_valid,
        .rsp_rdata, .in_retention, .mem_addr, .chip_select_n, .output_enable_n,
        .write_enable_n, .low_byte_enable_n, .high_byte_enable_n, .dq_in, .dq_out, .dq_oe);
    asram_model asram_model_i (.addr(mem_addr), .cs_n(chip_select_n), .oe_n(output_enable_n),
        .we_n(write_enable_n), .lb_n(low_byte_enable_n), .hb_n(high_byte_enable_n),
        .dq(dq_in), .q(q), .q_oe(q_oe));
    task give_verdict;
        begin
            if (n_fail == 0 && n_checks > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            n_checks++;
            if (g !== e) begin
                n_fail++;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task xfer(input iw, input [17:0] ia, input [15:0] id, input [1:0] il);
        begin
            @(posedge ref_clk);
            {req_valid, req_write, req_addr, req_wdata, req_lane_en} <= {1'b1, iw, ia, id, il};
            @(negedge ref_clk);
            for (t = 0; t < 50 && req_ready !== 1'b1; t++) @(negedge ref_clk);
            chk("ready", 16'h0001, {15'h0, req_ready});
            @(posedge ref_clk);
            req_valid <= 0;
            @(negedge ref_clk);
            for (t = 0; t < 50 && rsp_valid !== 1'b1; t++) @(negedge ref_clk);
            chk("answer", 16'h0001, {15'h0, rsp_valid});
            r = rsp_rdata;
        end
    endtask
    // no two drivers on a lane
    always @(negedge ref_clk) begin
        if (resetn && (dq_oe & q_oe) != 16'h0000)
            chk("bus fight", 16'h0000, dq_oe & q_oe);
    end
    initial begin
        #200000 n_fail++;
        give_verdict;
    end
    initial begin
        rows[0] = {1'b1, 18'h00000, 16'h1234, 2'h3}; rows[1] = {1'b0, 18'h00000, 16'h1234, 2'h3};
        rows[2] = {1'b1, 18'h00000, 16'hABCD, 2'h1}; rows[3] = {1'b0, 18'h00000, 16'h12CD, 2'h3};
        rows[4] = {1'b1, 18'h00000, 16'h5678, 2'h2}; rows[5] = {1'b0, 18'h00000, 16'h56CD, 2'h3};
        rows[6] = {1'b0, 18'h00000, 16'h00CD, 2'h1}; rows[7] = {1'b1, 18'h3FFFF, 16'hFFFF, 2'h3};
        rows[8] = {1'b1, 18'h3FFFF, 16'h0000, 2'h0}; rows[9] = {1'b0, 18'h3FFFF, 16'hFFFF, 2'h3};
        rows[10] = {1'b0, 18'h00000, 16'h5600, 2'h2};
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset pins", 16'h001F, {11'h0, chip_select_n, output_enable_n, write_enable_n,
            low_byte_enable_n, high_byte_enable_n});
        chk("reset oe", 16'h0000, dq_oe);
        @(posedge ref_clk) resetn <= 1;
        for (i = 0; i < 11; i++) begin
            {w, a, d, l} = rows[i];
            m = {{8{l[1]}}, {8{l[0]}}};
            xfer(w, a, d, l);
            if (!w) chk("rdata", d & m, r & m);
        end
        @(posedge ref_clk) retention_req <= 1;
        for (t = 0; t < 50 && in_retention !== 1'b1; t++) @(negedge ref_clk);
        chk("retention cs", 16'h0001, {15'h0, chip_select_n & in_retention});
        @(posedge ref_clk) retention_req <= 0;
        repeat (2) @(posedge ref_clk);
        xfer(1'b0, 18'h00000, 16'h0000, 2'h3);
        chk("rdata kept", 16'h56CD, r);
        give_verdict;
    end
endmodule // tb
